// [cssbu_defines.svh]
// opcode patterns, cycle counts, flag positions and reset values
// assumes 16-bit instruction words and a word-addressed program counter
`ifndef CSSBU_DEFINES_SVH
`define CSSBU_DEFINES_SVH

`define CSSBU_MASK_CMPI 16'hF000
`define CSSBU_PAT_CMPI 16'h3000
`define CSSBU_MASK_SKREG 16'hFE08
`define CSSBU_PAT_SKRC 16'hFC00
`define CSSBU_PAT_SKRS 16'hFE00
`define CSSBU_MASK_SKIO 16'hFF00
`define CSSBU_PAT_SKIC 16'h9900
`define CSSBU_PAT_SKIS 16'h9B00
`define CSSBU_MASK_BRF 16'hFC00
`define CSSBU_PAT_BRFS 16'hF000
`define CSSBU_PAT_BRFC 16'hF400
`define CSSBU_MASK_LDST 16'hFC0F
`define CSSBU_PAT_LDST 16'h9000
`define CSSBU_MASK_JMPCALL 16'hFE0C
`define CSSBU_PAT_JMPCALL 16'h940C

`define CSSBU_FLAG_C 0
`define CSSBU_FLAG_Z 1
`define CSSBU_FLAG_N 2
`define CSSBU_FLAG_V 3
`define CSSBU_FLAG_H 5

`define CSSBU_CMPI_BASE 5'h10
`define CSSBU_PC_RESET 0
`define CSSBU_STATUS_RESET 8'h00
`define CSSBU_CYC_PLAIN 2'h1
`define CSSBU_CYC_BRANCH 2'h2
`define CSSBU_CYC_SKIP1 2'h2
`define CSSBU_CYC_SKIP2 2'h3

`endif

// [cssbu_pkg.sv]
// types shared by the flow-control unit
// assumes cssbu_defines.svh carries the numeric constants
package cssbu_pkg;
   typedef enum logic [1:0] {
      CSSBU_IDLE = 2'b00,
      CSSBU_EVAL = 2'b01,
      CSSBU_WAIT = 2'b10
   } cssbu_state_t;

   typedef enum logic [2:0] {
      CSSBU_K_OTHER = 3'b000,
      CSSBU_K_CMPI = 3'b001,
      CSSBU_K_SKRC = 3'b010,
      CSSBU_K_SKRS = 3'b011,
      CSSBU_K_SKIC = 3'b100,
      CSSBU_K_SKIS = 3'b101,
      CSSBU_K_BRFS = 3'b110,
      CSSBU_K_BRFC = 3'b111
   } cssbu_kind_t;
endpackage : cssbu_pkg

// [cssbu_regfile.sv]
// general working registers, one write port, one registered read port
// assumes a single clock; read returns old data on a same-cycle write
`timescale 1ns/10ps
module cssbu_regfile #(
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule : cssbu_regfile

// [cssbu_unit.sv]
// conditional skip, flag branch and compare-immediate execution unit
// assumes the fetch side offers the instruction and the word after it
// Behaviour
// - skip on clear register bit advances the pc past the next instruction, flags kept.
// - skip on set register bit advances the pc past the next instruction, flags kept.
// - skip on clear i/o bit advances the pc past the next instruction, flags kept.
// - skip on set i/o bit advances the pc past the next instruction, flags kept.
// - branch on set flag loads pc plus signed offset plus one, else runs on, flags kept.
// - branch on clear flag loads pc plus signed offset plus one, else runs on, flags kept.
// - compare-immediate subtracts a constant, sets Z N V C H, stores nothing, one cycle.
`timescale 1ns/10ps
`include "cssbu_defines.svh"
module cssbu_unit #(
   parameter int PC_W = 12
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic [15:0] follow_word,
   output logic instr_ready,
   input wire logic reg_wr_en,
   input wire logic [4:0] reg_wr_addr,
   input wire logic [7:0] reg_wr_data,
   output logic [4:0] io_addr,
   input wire logic [7:0] io_rd_data,
   input wire logic status_wr_en,
   input wire logic [7:0] status_wr_data,
   input wire logic pc_load_en,
   input wire logic [PC_W-1:0] pc_load_value,
   output logic [PC_W-1:0] pc,
   output logic [7:0] status,
   output logic retire,
   output logic skip_taken,
   output logic branch_taken
);
   cssbu_pkg::cssbu_state_t state_reg;
   cssbu_pkg::cssbu_kind_t kind;
   logic [15:0] instr_reg;
   logic [15:0] follow_reg;
   logic [4:0] rd_addr;
   logic [7:0] rd_data;
   logic [1:0] wait_reg;
   logic [1:0] cycles;
   logic [PC_W-1:0] pc_next;
   logic [7:0] status_next;
   logic skip_next;
   logic branch_next;
   logic accept;

   function automatic cssbu_pkg::cssbu_kind_t decode(input logic [15:0] w);
      cssbu_pkg::cssbu_kind_t k;
      k = cssbu_pkg::CSSBU_K_OTHER;
      if ((w & `CSSBU_MASK_CMPI) == `CSSBU_PAT_CMPI) k = cssbu_pkg::CSSBU_K_CMPI;
      if ((w & `CSSBU_MASK_SKREG) == `CSSBU_PAT_SKRC) k = cssbu_pkg::CSSBU_K_SKRC;
      if ((w & `CSSBU_MASK_SKREG) == `CSSBU_PAT_SKRS) k = cssbu_pkg::CSSBU_K_SKRS;
      if ((w & `CSSBU_MASK_SKIO) == `CSSBU_PAT_SKIC) k = cssbu_pkg::CSSBU_K_SKIC;
      if ((w & `CSSBU_MASK_SKIO) == `CSSBU_PAT_SKIS) k = cssbu_pkg::CSSBU_K_SKIS;
      if ((w & `CSSBU_MASK_BRF) == `CSSBU_PAT_BRFS) k = cssbu_pkg::CSSBU_K_BRFS;
      if ((w & `CSSBU_MASK_BRF) == `CSSBU_PAT_BRFC) k = cssbu_pkg::CSSBU_K_BRFC;
      return k;
   endfunction : decode

   // two-word instructions decide how far a skip must jump
   function automatic logic is_double(input logic [15:0] w);
      return ((w & `CSSBU_MASK_LDST) == `CSSBU_PAT_LDST) ||
         ((w & `CSSBU_MASK_JMPCALL) == `CSSBU_PAT_JMPCALL);
   endfunction : is_double

   // compare flags from the subtraction rd - k
   function automatic logic [7:0] cmp_flags(input logic [7:0] sr, input logic [7:0] a,
                                            input logic [7:0] b);
      logic [7:0] r;
      logic [7:0] f;
      r = a - b;
      f = sr;
      f[`CSSBU_FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      f[`CSSBU_FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      f[`CSSBU_FLAG_N] = r[7];
      f[`CSSBU_FLAG_Z] = (r == 8'h00);
      f[`CSSBU_FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      return f;
   endfunction : cmp_flags

   assign accept = instr_valid && instr_ready;
   assign kind = decode(instr_reg);

   // read port address chosen at issue so data is ready in the eval cycle
   always_comb begin
      if (decode(instr_word) == cssbu_pkg::CSSBU_K_CMPI) begin
         rd_addr = `CSSBU_CMPI_BASE | {1'b0, instr_word[7:4]};
      end else begin
         rd_addr = instr_word[8:4];
      end
   end

   cssbu_regfile #(
      .DEPTH(32),
      .AW(5)
   ) u_regs (
      .clk(clk),
      .srst(srst),
      .wr_en(reg_wr_en),
      .wr_addr(reg_wr_addr),
      .wr_data(reg_wr_data),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // outcome of the held instruction, used only in the eval cycle
   always_comb begin
      logic cond;
      logic [PC_W-1:0] offs;
      cond = 1'b0;
      offs = PC_W'({{(PC_W-7){instr_reg[9]}}, instr_reg[9:3]});
      pc_next = pc + PC_W'(1);
      status_next = status;
      skip_next = 1'b0;
      branch_next = 1'b0;
      cycles = `CSSBU_CYC_PLAIN;
      unique case (kind)
         cssbu_pkg::CSSBU_K_CMPI: begin
            status_next = cmp_flags(status, rd_data, {instr_reg[11:8], instr_reg[3:0]});
         end
         cssbu_pkg::CSSBU_K_SKRC: cond = ~rd_data[instr_reg[2:0]];
         cssbu_pkg::CSSBU_K_SKRS: cond = rd_data[instr_reg[2:0]];
         cssbu_pkg::CSSBU_K_SKIC: cond = ~io_rd_data[instr_reg[2:0]];
         cssbu_pkg::CSSBU_K_SKIS: cond = io_rd_data[instr_reg[2:0]];
         cssbu_pkg::CSSBU_K_BRFS: cond = status[instr_reg[2:0]];
         cssbu_pkg::CSSBU_K_BRFC: cond = ~status[instr_reg[2:0]];
         cssbu_pkg::CSSBU_K_OTHER: cond = 1'b0;
      endcase
      if (cond) begin
         if (kind == cssbu_pkg::CSSBU_K_BRFS || kind == cssbu_pkg::CSSBU_K_BRFC) begin
            pc_next = pc + offs + PC_W'(1);
            branch_next = 1'b1;
            cycles = `CSSBU_CYC_BRANCH;
         end else if (is_double(follow_reg)) begin
            pc_next = pc + PC_W'(3);
            skip_next = 1'b1;
            cycles = `CSSBU_CYC_SKIP2;
         end else begin
            pc_next = pc + PC_W'(2);
            skip_next = 1'b1;
            cycles = `CSSBU_CYC_SKIP1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= cssbu_pkg::CSSBU_IDLE;
         instr_ready <= 1'b0;
         wait_reg <= 2'h0;
      end else begin
         unique case (state_reg)
            cssbu_pkg::CSSBU_IDLE: begin
               instr_ready <= 1'b1;
               if (accept) begin
                  state_reg <= cssbu_pkg::CSSBU_EVAL;
                  instr_ready <= 1'b0;
               end
            end
            cssbu_pkg::CSSBU_EVAL: begin
               // extra cycles stall issue so the count is visible to fetch
               wait_reg <= cycles - 2'h1;
               if (cycles == `CSSBU_CYC_PLAIN) begin
                  state_reg <= cssbu_pkg::CSSBU_IDLE;
                  instr_ready <= 1'b1;
               end else begin
                  state_reg <= cssbu_pkg::CSSBU_WAIT;
               end
            end
            cssbu_pkg::CSSBU_WAIT: begin
               wait_reg <= wait_reg - 2'h1;
               if (wait_reg == 2'h1) begin
                  state_reg <= cssbu_pkg::CSSBU_IDLE;
                  instr_ready <= 1'b1;
               end
            end
            default: begin
               state_reg <= cssbu_pkg::CSSBU_IDLE;
               instr_ready <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         instr_reg <= 16'h0000;
         follow_reg <= 16'h0000;
         io_addr <= 5'h00;
      end else if (accept) begin
         instr_reg <= instr_word;
         follow_reg <= follow_word;
         io_addr <= instr_word[7:3];
      end
   end

   // execution owns pc and flags in eval; outside loads apply in idle or wait and are dropped in eval
   always_ff @(posedge clk) begin
      if (srst) begin
         pc <= PC_W'(`CSSBU_PC_RESET);
         status <= `CSSBU_STATUS_RESET;
      end else if (state_reg == cssbu_pkg::CSSBU_EVAL) begin
         pc <= pc_next;
         status <= status_next;
      end else begin
         if (pc_load_en) begin
            pc <= pc_load_value;
         end
         if (status_wr_en) begin
            status <= status_wr_data;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         retire <= 1'b0;
         skip_taken <= 1'b0;
         branch_taken <= 1'b0;
      end else begin
         retire <= (state_reg == cssbu_pkg::CSSBU_EVAL && cycles == `CSSBU_CYC_PLAIN) ||
            (state_reg == cssbu_pkg::CSSBU_WAIT && wait_reg == 2'h1);
         skip_taken <= (state_reg == cssbu_pkg::CSSBU_EVAL) && skip_next;
         branch_taken <= (state_reg == cssbu_pkg::CSSBU_EVAL) && branch_next;
      end
   end
endmodule : cssbu_unit

// [cssbu_unit_chk.sv]
// port timing checks for the flow-control unit
// assumes binding onto cssbu_unit, one clock domain
`timescale 1ns/10ps
`include "cssbu_defines.svh"
module cssbu_unit_chk #(
   parameter int PC_W = 12
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic instr_ready,
   input wire logic [PC_W-1:0] pc,
   input wire logic [7:0] status,
   input wire logic retire,
   input wire logic skip_taken,
   input wire logic branch_taken
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_cmp_acc;
      instr_valid && instr_ready && ((instr_word & `CSSBU_MASK_CMPI) == `CSSBU_PAT_CMPI);
   endsequence
   sequence s_skip_end;
      skip_taken ##[1:2] retire;
   endsequence
   AST_CMP_ONE: assert property (s_cmp_acc |-> ##2 (retire && !skip_taken && !branch_taken))
      else $error("compare did not retire in one cycle");
   AST_SKIP_END: assert property (skip_taken |-> s_skip_end)
      else $error("skip did not retire in two or three cycles");
   AST_SKIP_PC: assert property (skip_taken |-> (PC_W'(pc - $past(pc)) inside {2, 3}))
      else $error("skip moved pc by other than two or three");
   AST_SKIP_FLAGS: assert property (skip_taken |-> $stable(status))
      else $error("skip changed status");
   AST_BR_FLAGS: assert property (branch_taken |-> $stable(status))
      else $error("branch changed status");
   AST_BR_END: assert property (branch_taken |-> !retire ##1 retire)
      else $error("taken branch did not take two cycles");
   AST_BUSY: assert property (instr_valid && instr_ready |=> !instr_ready)
      else $error("ready stayed high after accept");
   AST_RET_PULSE: assert property (retire |=> !retire && !skip_taken)
      else $error("retire longer than one cycle");
endmodule : cssbu_unit_chk

bind cssbu_unit cssbu_unit_chk #(.PC_W(PC_W)) u_chk (.clk(clk), .srst(srst),
   .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready), .pc(pc),
   .status(status), .retire(retire), .skip_taken(skip_taken), .branch_taken(branch_taken));

// [conditional_skip_branch_unit_test.sv]
// self-checking bench for the flow-control unit
// assumes cssbu_unit with PC_W 12 and the bound checker
`timescale 1ns/10ps
module conditional_skip_branch_unit_test;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic [15:0] follow_word = 16'h0000;
   logic reg_wr_en = 1'b0;
   logic [4:0] reg_wr_addr = 5'h00;
   logic [7:0] reg_wr_data = 8'h00;
   logic [7:0] io_rd_data = 8'h00;
   logic status_wr_en = 1'b0;
   logic [7:0] status_wr_data = 8'h00;
   logic pc_load_en = 1'b0;
   logic [11:0] pc_load_value = 12'h000;
   logic instr_ready, retire, skip_taken, branch_taken;
   logic [4:0] io_addr;
   logic [11:0] pc, p;
   logic [7:0] status;
   int n_errors = 0;
   int cmp_count = 0;
   always #25 clk = ~clk;
   cssbu_unit #(.PC_W(12)) DUT (.clk(clk), .srst(srst), .instr_valid(instr_valid),
      .instr_word(instr_word), .follow_word(follow_word), .instr_ready(instr_ready),
      .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
      .io_addr(io_addr), .io_rd_data(io_rd_data), .status_wr_en(status_wr_en),
      .status_wr_data(status_wr_data), .pc_load_en(pc_load_en), .pc_load_value(pc_load_value),
      .pc(pc), .status(status), .retire(retire), .skip_taken(skip_taken),
      .branch_taken(branch_taken));
   task automatic test_done;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp16
   task automatic load(input logic [11:0] pv, input logic [7:0] sv, input logic [4:0] a,
                       input logic [7:0] d);
      @(negedge clk);
      pc_load_en = 1'b1;
      pc_load_value = pv;
      status_wr_en = 1'b1;
      status_wr_data = sv;
      reg_wr_en = 1'b1;
      reg_wr_addr = a;
      reg_wr_data = d;
      @(negedge clk);
      pc_load_en = 1'b0;
      status_wr_en = 1'b0;
      reg_wr_en = 1'b0;
      p = pv;
   endtask : load
   // bounded waits; cycles counted at falling edges after the accept edge
   task automatic run(input logic [15:0] iw, input logic [15:0] fw, input logic [11:0] d,
                      input logic [1:0] cyc);
      int n;
      logic sk;
      logic br;
      logic ebr;
      sk = 1'b0;
      br = 1'b0;
      // flag-branch opcodes start 11110; taken ones are the two-cycle kind
      ebr = (iw[15:11] == 5'h1E) && (cyc == 2'h2);
      for (n = 0; n < 20 && instr_ready !== 1'b1; n++) @(negedge clk);
      if (n >= 20) begin
         n_errors++;
         $display("mismatch at %0t: never ready", $time);
         test_done;
      end
      instr_word = iw;
      follow_word = fw;
      instr_valid = 1'b1;
      @(negedge clk);
      instr_valid = 1'b0;
      for (n = 0; n < 20 && retire !== 1'b1; n++) begin
         @(negedge clk);
         sk = sk | skip_taken;
         br = br | branch_taken;
      end
      if (n >= 20) begin
         n_errors++;
         $display("mismatch at %0t: no retire", $time);
         test_done;
      end
      p = p + d;
      cmp16({4'h0, pc}, {4'h0, p});
      cmp16({14'h0000, n[1:0]}, {14'h0000, cyc});
      cmp16({14'h0000, sk, br}, {14'h0000, (cyc != 2'h1) && !ebr, ebr});
   endtask : run
   // bits 4 and 6 preset to show compare leaves them alone
   task automatic t_compare;
      logic [7:0] av [3] = '{8'h10, 8'h00, 8'h7F};
      logic [7:0] kv [3] = '{8'h10, 8'h01, 8'h80};
      logic [7:0] ev [3] = '{8'h52, 8'h75, 8'h5D};
      for (int i = 0; i < 3; i++) begin
         load(12'h020, 8'h50, 5'(16 + i), av[i]);
         run({4'h3, kv[i][7:4], 4'(i), kv[i][3:0]}, 16'h0000, 12'h001, 2'h1);
         cmp16({8'h00, status}, {8'h00, ev[i]});
      end
   endtask : t_compare
   task automatic t_reg_skip;
      load(12'h100, 8'hA5, 5'h05, 8'h08);
      run({7'h7E, 5'h05, 1'b0, 3'h2}, 16'h0000, 12'h002, 2'h2);
      run({7'h7E, 5'h05, 1'b0, 3'h3}, 16'h0000, 12'h001, 2'h1);
      run({7'h7F, 5'h05, 1'b0, 3'h3}, 16'h940C, 12'h003, 2'h3);
      run({7'h7F, 5'h05, 1'b0, 3'h0}, 16'h9000, 12'h001, 2'h1);
      cmp16({8'h00, status}, 16'h00A5);
   endtask : t_reg_skip
   task automatic t_io_skip;
      load(12'h200, 8'h5A, 5'h00, 8'h00);
      io_rd_data = 8'h01;
      run({8'h99, 5'h07, 3'h0}, 16'h0000, 12'h001, 2'h1);
      cmp16({11'h000, io_addr}, 16'h0007);
      run({8'h99, 5'h1F, 3'h1}, 16'h9000, 12'h003, 2'h3);
      run({8'h9B, 5'h03, 3'h0}, 16'h0000, 12'h002, 2'h2);
      run({8'h9B, 5'h03, 3'h1}, 16'h0000, 12'h001, 2'h1);
      cmp16({8'h00, status}, 16'h005A);
   endtask : t_io_skip
   task automatic t_branch;
      load(12'h100, 8'h02, 5'h00, 8'h00);
      run({6'h3C, 7'h7E, 3'h1}, 16'h0000, 12'hFFF, 2'h2);
      run({6'h3C, 7'h05, 3'h0}, 16'h0000, 12'h001, 2'h1);
      run({6'h3D, 7'h05, 3'h0}, 16'h0000, 12'h006, 2'h2);
      run({6'h3D, 7'h05, 3'h1}, 16'h0000, 12'h001, 2'h1);
      cmp16({8'h00, status}, 16'h0002);
   endtask : t_branch
   initial begin
      repeat (12) @(negedge clk);
      srst = 1'b0;
      t_compare;
      t_reg_skip;
      t_io_skip;
      t_branch;
      test_done;
   end
endmodule : conditional_skip_branch_unit_test
